// *** logic/acc_pkg.sv ***
// Package for the conversion-control block: register map, field layout,
// timing constants and packed carriers.
// Assumes a 32-bit AXI4-Lite register bus and one 20 MHz clock.
package acc_pkg;

  // Register byte addresses
  localparam logic [3:0] ACC_CSR_ADDR  = 4'h0;
  localparam logic [3:0] ACC_STAT_ADDR = 4'h4;

  // Control/status field positions
  localparam int ACC_FLAG_BIT  = 7;
  localparam int ACC_IE_BIT    = 6;
  localparam int ACC_START_BIT = 5;
  localparam int ACC_SCAN_BIT  = 4;
  localparam int ACC_TSEL_BIT  = 3;
  localparam int ACC_LAST_BIT  = 2;

  // Conversion time in states
  localparam int ACC_SLOW_STATES = 266;
  localparam int ACC_FAST_STATES = 134;
  localparam int ACC_CNT_W       = 9;
  localparam logic [ACC_CNT_W-1:0] ACC_SLOW_CNT = 9'h10A;
  localparam logic [ACC_CNT_W-1:0] ACC_FAST_CNT = 9'h086;

  // AXI responses
  localparam logic [1:0] ACC_RESP_OKAY   = 2'h0;
  localparam logic [1:0] ACC_RESP_SLVERR = 2'h2;

  typedef struct packed {
    logic flag;
    logic irq_en;
    logic start;
    logic scan;
    logic tsel;
  } acc_ctrl_t;

  typedef enum logic [1:0] {ACC_IDLE, ACC_CONV} acc_state_t;

endpackage

// *** logic/acc_timer.sv ***
// Conversion-time counter: pulses done after the selected state count.
// Assumes start is a one-cycle pulse and abort stops the count at once.
`timescale 1ns/100ps
module acc_timer
  import acc_pkg::*;
(
  // Clock and reset
  input  wire logic aclk,
  input  wire logic aresetn,
  // Control
  input  wire logic start,
  input  wire logic abort,
  input  wire logic fast,
  // Status
  output logic      busy,
  output logic      done
);

  logic [ACC_CNT_W-1:0] cnt_q;
  logic                 busy_q;
  logic                 done_q;
  wire  [ACC_CNT_W-1:0] load_val = fast ? ACC_FAST_CNT : ACC_SLOW_CNT;
  wire                  last     = busy_q && (cnt_q == 9'h001);

  always_ff @(posedge aclk)
  begin
    if (!aresetn || abort)
    begin
      cnt_q  <= '0;
      busy_q <= 1'b0;
      done_q <= 1'b0;
    end
    else if (start)
    begin
      cnt_q  <= load_val;
      busy_q <= 1'b1;
      done_q <= 1'b0;
    end
    else
    begin
      cnt_q  <= busy_q ? cnt_q - 9'h001 : cnt_q;
      busy_q <= busy_q && !last;
      done_q <= last;
    end
  end

  assign busy = busy_q;
  assign done = done_q;

endmodule

// *** logic/acc_top.sv ***
// Conversion-control block of an on-chip A/D converter with AXI4-Lite
// control/status register, timer and external triggers.
// Assumes all inputs synchronous to aclk; channel count is a parameter.
// Behaviour
// - The end interrupt request is blocked while its enable is 0.
// - The start bit reads 1 for as long as a conversion runs.
// - Software, the timer trigger or the external trigger sets start.
// - Writing 0 to start stops conversion, and start resets to 0.
// - Single mode converts one channel, then hardware clears start.
// - Scan mode repeats the channel sequence until start is cleared.
// - Bit 4 selects single (0) or scan (1) mode and resets to 0.
// - Bit 3 selects 266 (0) or 134 (1) states and resets to 0.
// - The end flag sets after a single conversion or a full scan.
// - The end flag clears on 0 written after reading 1 or a DTC read.
`timescale 1ns/100ps
module acc_top
  import acc_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  // Clock and reset
  input  wire logic        aclk,
  input  wire logic        aresetn,
  // AXI4-Lite write address
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [3:0]  s_axi_awaddr,
  // AXI4-Lite write data
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  // AXI4-Lite write response
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  output logic [1:0]       s_axi_bresp,
  // AXI4-Lite read address
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  input  wire logic [3:0]  s_axi_araddr,
  // AXI4-Lite read data
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  // Triggers, power modes and DTC result read
  input  wire logic        timer_conv_trigger,
  input  wire logic        external_conv_trigger_n,
  input  wire logic        standby_mode,
  input  wire logic        module_stop,
  input  wire logic        dtc_result_read,
  // Converter side
  output logic             conv_active,
  output logic [$clog2(NUM_CH)-1:0] conv_channel,
  output logic             conv_end_irq
);

  localparam int CH_W = $clog2(NUM_CH);
  localparam logic [CH_W-1:0] CH_LAST = CH_W'(NUM_CH - 1);

  acc_ctrl_t           ctrl_q;
  acc_state_t          state_q;
  logic [CH_W-1:0]     ch_q;
  logic                flag_seen_q;
  logic                aw_q;
  logic [3:0]          awaddr_q;
  logic                w_q;
  logic [31:0]         wdata_q;
  logic                wstrb0_q;
  logic                bvalid_q;
  logic [1:0]          bresp_q;
  logic                rvalid_q;
  logic [31:0]         rdata_q;
  logic [1:0]          rresp_q;
  logic                irq_q;
  logic                tmr_busy;
  logic                tmr_done;
  logic                aw_rdy_q;
  logic                w_rdy_q;
  logic                ar_rdy_q;

  // Write channel handshakes
  wire aw_take  = s_axi_awvalid && aw_rdy_q;
  wire w_take   = s_axi_wvalid && w_rdy_q;
  wire wr_fire  = aw_q && w_q && !bvalid_q;
  wire wr_csr   = wr_fire && (awaddr_q == ACC_CSR_ADDR) && wstrb0_q;
  wire wr_ok    = (awaddr_q == ACC_CSR_ADDR) || (awaddr_q == ACC_STAT_ADDR);

  // Channel occupancy after this edge, feeds the registered readies
  wire aw_next  = !wr_fire && (aw_q || aw_take);
  wire w_next   = !wr_fire && (w_q || w_take);
  wire b_next   = wr_fire || (bvalid_q && !s_axi_bready);

  // Read channel handshake
  wire ar_take  = s_axi_arvalid && ar_rdy_q;
  wire r_next   = ar_take || (rvalid_q && !s_axi_rready);
  wire rd_csr   = ar_take && (s_axi_araddr == ACC_CSR_ADDR);
  wire rd_stat  = ar_take && (s_axi_araddr == ACC_STAT_ADDR);

  // Software intent from the written byte
  wire sw_start = wr_csr && wdata_q[ACC_START_BIT];
  wire sw_stop  = wr_csr && !wdata_q[ACC_START_BIT];
  wire sw_fclr  = wr_csr && !wdata_q[ACC_FLAG_BIT] && flag_seen_q;
  wire idle_wr  = wr_csr && !ctrl_q.start;

  // Start sources and stop sources
  wire trig     = timer_conv_trigger || !external_conv_trigger_n;
  wire halt     = standby_mode || module_stop || sw_stop;
  wire set_req  = (sw_start || trig) && !halt;
  wire kick     = set_req && (state_q == ACC_IDLE) && !tmr_busy;
  wire at_last  = (ch_q == CH_LAST);

  // Conversion progress
  wire single_end = tmr_done && !ctrl_q.scan;
  wire scan_end   = tmr_done && ctrl_q.scan && at_last;
  wire next_conv  = tmr_done && ctrl_q.scan && !halt;
  wire flag_set   = single_end || scan_end;
  wire flag_clr   = sw_fclr || dtc_result_read;
  wire flag_clr_only = flag_clr && !flag_set;

  acc_timer u_timer
  (
    .aclk    (aclk),
    .aresetn (aresetn),
    .start   (kick || next_conv),
    .abort   (halt),
    .fast    (ctrl_q.tsel),
    .busy    (tmr_busy),
    .done    (tmr_done)
  );

  // AXI write side
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_q     <= 1'b0;
      awaddr_q <= 4'h0;
      w_q      <= 1'b0;
      wdata_q  <= 32'h0;
      wstrb0_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q  <= ACC_RESP_OKAY;
    end
    else
    begin
      if (aw_take)
      begin
        aw_q     <= 1'b1;
        awaddr_q <= s_axi_awaddr;
      end
      if (w_take)
      begin
        w_q      <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb0_q <= s_axi_wstrb[0];
      end
      if (wr_fire)
      begin
        aw_q     <= 1'b0;
        w_q      <= 1'b0;
        bvalid_q <= 1'b1;
        bresp_q  <= wr_ok ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
      end
      else if (bvalid_q && s_axi_bready)
      begin
        bvalid_q <= 1'b0;
      end
    end
  end

  // Registered channel readies
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_rdy_q <= 1'b0;
      w_rdy_q  <= 1'b0;
      ar_rdy_q <= 1'b0;
    end
    else
    begin
      aw_rdy_q <= !aw_next && !b_next;
      w_rdy_q  <= !w_next && !b_next;
      ar_rdy_q <= !r_next;
    end
  end

  // AXI read side
  wire [31:0] csr_val = {24'h0, ctrl_q.flag, ctrl_q.irq_en, ctrl_q.start,
                         ctrl_q.scan, ctrl_q.tsel, 3'h0};
  wire [31:0] stat_val = {{(32-CH_W-2){1'b0}}, ch_q, at_last,
                          (state_q == ACC_CONV)};
  wire [31:0] rd_val = rd_csr ? csr_val : (rd_stat ? stat_val : 32'h0);

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rvalid_q <= 1'b0;
      rdata_q  <= 32'h0;
      rresp_q  <= ACC_RESP_OKAY;
    end
    else if (ar_take)
    begin
      rvalid_q <= 1'b1;
      rdata_q  <= rd_val;
      rresp_q  <= (rd_csr || rd_stat) ? ACC_RESP_OKAY : ACC_RESP_SLVERR;
    end
    else if (rvalid_q && s_axi_rready)
    begin
      rvalid_q <= 1'b0;
    end
  end

  // Control register and conversion sequencing
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      ctrl_q      <= '0;
      state_q     <= ACC_IDLE;
      ch_q        <= '0;
      flag_seen_q <= 1'b0;
      irq_q       <= 1'b0;
    end
    else
    begin
      if (wr_csr)
      begin
        ctrl_q.irq_en <= wdata_q[ACC_IE_BIT];
      end
      if (idle_wr)
      begin
        ctrl_q.scan <= wdata_q[ACC_SCAN_BIT];
        ctrl_q.tsel <= wdata_q[ACC_TSEL_BIT];
      end
      if (flag_set)
      begin
        ctrl_q.flag <= 1'b1;
      end
      else if (flag_clr)
      begin
        ctrl_q.flag <= 1'b0;
      end
      if (rd_csr && ctrl_q.flag)
      begin
        flag_seen_q <= 1'b1;
      end
      else if (flag_clr || flag_set)
      begin
        flag_seen_q <= 1'b0;
      end
      case (state_q)
        ACC_IDLE:
        begin
          ch_q <= '0;
          if (kick)
          begin
            ctrl_q.start <= 1'b1;
            state_q      <= ACC_CONV;
          end
          else
          begin
            ctrl_q.start <= 1'b0;
          end
        end
        ACC_CONV:
        begin
          if (halt || single_end)
          begin
            ctrl_q.start <= 1'b0;
            state_q      <= ACC_IDLE;
            ch_q         <= '0;
          end
          else if (tmr_done)
          begin
            ch_q <= at_last ? '0 : ch_q + 1'b1;
          end
        end
        default:
        begin
          state_q <= ACC_IDLE;
        end
      endcase
      irq_q <= (ctrl_q.flag || flag_set) && !flag_clr_only &&
               ctrl_q.irq_en;
    end
  end

  // Outputs
  assign s_axi_awready = aw_rdy_q;
  assign s_axi_wready  = w_rdy_q;
  assign s_axi_bvalid  = bvalid_q;
  assign s_axi_bresp   = bresp_q;
  assign s_axi_arready = ar_rdy_q;
  assign s_axi_rvalid  = rvalid_q;
  assign s_axi_rdata   = rdata_q;
  assign s_axi_rresp   = rresp_q;
  assign conv_active   = ctrl_q.start;
  assign conv_channel  = ch_q;
  assign conv_end_irq  = irq_q;

endmodule

// *** sim/acc_sva.sv ***
// Checker for the conversion-control block, bound to acc_top.
// Sees only the top module's ports.
`timescale 1ns/100ps
module acc_sva
  import acc_pkg::*;
#(
  parameter int NUM_CH = 4
)
(
  // Clock and reset
  input logic                      aclk,
  input logic                      aresetn,
  // Bus handshakes
  input logic                      s_axi_arvalid,
  input logic                      s_axi_arready,
  input logic                      s_axi_rvalid,
  input logic                      s_axi_rready,
  input logic                      s_axi_bvalid,
  input logic                      s_axi_bready,
  // Triggers and power modes
  input logic                      timer_conv_trigger,
  input logic                      external_conv_trigger_n,
  input logic                      standby_mode,
  input logic                      module_stop,
  // Converter side
  input logic                      conv_active,
  input logic                      conv_end_irq,
  input logic [$clog2(NUM_CH)-1:0] conv_channel
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  rst_idle_a: assert property (
    disable iff (1'h0) !aresetn |=> !conv_active && !conv_end_irq)
    else $error("active after reset");
  timer_start_a: assert property (
    !conv_active && timer_conv_trigger && !standby_mode && !module_stop
    |=> conv_active) else $error("timer trigger ignored");
  ext_start_a: assert property (
    !conv_active && !external_conv_trigger_n && !standby_mode
    && !module_stop |=> conv_active) else $error("pin trigger ignored");
  standby_stop_a: assert property (
    standby_mode |=> !conv_active) else $error("standby kept running");
  mstop_stop_a: assert property (
    module_stop |=> !conv_active) else $error("module stop kept running");
  chan_step_a: assert property (
    conv_channel != $past(conv_channel) |-> conv_channel == 0
    || conv_channel == $past(conv_channel) + 1'h1) else $error("bad step");
  bresp_hold_a: assert property (
    s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("bvalid dropped");
  rresp_hold_a: assert property (
    s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
    else $error("rvalid dropped");
  read_answer_a: assert property (
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read not answered");
endmodule

// *** sim/acc_trig_model.sv ***
// Trigger source model: timer start pulse and external trigger pin.
// Bench requests arrive on aclk; the pin idles high.
`timescale 1ns/100ps
module acc_trig_model
(
  // Clock and requests
  input  logic aclk,
  input  logic fire_t,
  input  logic fire_e,
  // Trigger outputs
  output logic timer_conv_trigger      = 1'h0,
  output logic external_conv_trigger_n = 1'h1
);
  // One-cycle pulses, pin active low
  always @(posedge aclk)
  begin
    timer_conv_trigger <= fire_t;
    external_conv_trigger_n <= !fire_e;
  end
endmodule

// *** sim/tb_top.sv ***
// Self-checking bench for acc_top over AXI4-Lite.
// Assumes acc_trig_model and acc_sva are compiled beside it.
`timescale 1ns/100ps
module tb_top
  import acc_pkg::*;
  ;
  logic aclk = 1'h0, aresetn = 1'h0, fire_t = 1'h0, fire_e = 1'h0;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic [3:0] s_axi_awaddr = 4'h0, s_axi_araddr = 4'h0, s_axi_wstrb = 4'hF;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, rd;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid;
  logic s_axi_arready, s_axi_rvalid, conv_active, conv_end_irq;
  logic [1:0] s_axi_bresp, s_axi_rresp, conv_channel, rr, br;
  logic standby_mode = 1'h0, module_stop = 1'h0, dtc_result_read = 1'h0;
  logic timer_conv_trigger, external_conv_trigger_n;
  int n_errors = 0, checks_done = 0, n;
  acc_top #(.NUM_CH(4)) DUT
  (
    .aclk                    (aclk),
    .aresetn                 (aresetn),
    .s_axi_awvalid           (s_axi_awvalid),
    .s_axi_awready           (s_axi_awready),
    .s_axi_awaddr            (s_axi_awaddr),
    .s_axi_wvalid            (s_axi_wvalid),
    .s_axi_wready            (s_axi_wready),
    .s_axi_wdata             (s_axi_wdata),
    .s_axi_wstrb             (s_axi_wstrb),
    .s_axi_bvalid            (s_axi_bvalid),
    .s_axi_bready            (s_axi_bready),
    .s_axi_bresp             (s_axi_bresp),
    .s_axi_arvalid           (s_axi_arvalid),
    .s_axi_arready           (s_axi_arready),
    .s_axi_araddr            (s_axi_araddr),
    .s_axi_rvalid            (s_axi_rvalid),
    .s_axi_rready            (s_axi_rready),
    .s_axi_rdata             (s_axi_rdata),
    .s_axi_rresp             (s_axi_rresp),
    .timer_conv_trigger      (timer_conv_trigger),
    .external_conv_trigger_n (external_conv_trigger_n),
    .standby_mode            (standby_mode),
    .module_stop             (module_stop),
    .dtc_result_read         (dtc_result_read),
    .conv_active             (conv_active),
    .conv_channel            (conv_channel),
    .conv_end_irq            (conv_end_irq)
  );
  acc_trig_model u_trig
  (
    .aclk                    (aclk),
    .fire_t                  (fire_t),
    .fire_e                  (fire_e),
    .timer_conv_trigger      (timer_conv_trigger),
    .external_conv_trigger_n (external_conv_trigger_n)
  );
  always #25 aclk = ~aclk;
  task final_report;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  task tmo;
    n_errors++;
    final_report();
  endtask
  task chk(input string nm, input logic [31:0] got, exp);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("MISMATCH %s exp %h got %h", nm, exp, got);
    end
  endtask
  task cyc(input int k);
    repeat (k) @(negedge aclk);
  endtask
  task wr(input logic [3:0] a, input logic [31:0] d);
    int i;
    logic ta, tw, tb;
    @(posedge aclk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      br = s_axi_bresp;
      @(posedge aclk);
      if (ta) s_axi_awvalid <= 1'h0;
      if (tw) s_axi_wvalid <= 1'h0;
      if (tb) break;
    end
    s_axi_bready <= 1'h0;
    if (i == 50) tmo();
  endtask
  task rdr(input logic [3:0] a);
    int i;
    logic ta, tr;
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (i = 0; i < 50; i++)
    begin
      @(negedge aclk);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      rd = s_axi_rdata;
      rr = s_axi_rresp;
      @(posedge aclk);
      if (ta) s_axi_arvalid <= 1'h0;
      if (tr) break;
    end
    s_axi_rready <= 1'h0;
    if (i == 50) tmo();
  endtask
  task wait_idle(input int exp);
    for (n = 0; n < 2000; n++)
    begin
      @(negedge aclk);
      if (!conv_active) break;
    end
    if (n == 2000) tmo();
    chk("conv time", 32'(n >= exp - 8 && n <= exp), 32'h1);
  endtask
  task t_reset;
    rdr(ACC_CSR_ADDR);
    chk("csr reset", rd, 32'h0);
    chk("rd okay", 32'(rr), 32'(ACC_RESP_OKAY));
    rdr(ACC_STAT_ADDR);
    chk("stat reset", rd, 32'h0);
    rdr(4'h8);
    chk("unmapped", 32'(rr), 32'(ACC_RESP_SLVERR));
    wr(4'h8, 32'h0);
    chk("wr unmapped", 32'(br), 32'(ACC_RESP_SLVERR));
  endtask
  task t_slow;
    wr(ACC_CSR_ADDR, 32'h20);
    rdr(ACC_CSR_ADDR);
    chk("start bit", rd, 32'h20);
    wait_idle(ACC_SLOW_STATES);
    cyc(3);
    chk("irq masked", 32'(conv_end_irq), 32'h0);
    rdr(ACC_CSR_ADDR);
    chk("end flag", rd, 32'h80);
    wr(ACC_CSR_ADDR, 32'hC0);
    cyc(3);
    chk("irq on", 32'(conv_end_irq), 32'h1);
    wr(ACC_CSR_ADDR, 32'h40);
    cyc(3);
    chk("flag clear", 32'(conv_end_irq), 32'h0);
  endtask
  task t_trig;
    wr(ACC_CSR_ADDR, 32'h48);
    @(posedge aclk) fire_t <= 1'h1;
    @(posedge aclk) fire_t <= 1'h0;
    cyc(2);
    chk("timer start", 32'(conv_active), 32'h1);
    wait_idle(ACC_FAST_STATES);
    cyc(3);
    chk("irq end", 32'(conv_end_irq), 32'h1);
    @(posedge aclk) dtc_result_read <= 1'h1;
    @(posedge aclk) dtc_result_read <= 1'h0;
    cyc(3);
    chk("dtc clear", 32'(conv_end_irq), 32'h0);
    @(posedge aclk) fire_e <= 1'h1;
    @(posedge aclk) fire_e <= 1'h0;
    cyc(2);
    rdr(ACC_CSR_ADDR);
    chk("pin start", rd, 32'h68);
    wr(ACC_CSR_ADDR, 32'h48);
    cyc(2);
    rdr(ACC_CSR_ADDR);
    chk("sw stop", rd, 32'h48);
  endtask
  task t_scan;
    wr(ACC_CSR_ADDR, 32'h18);
    wr(ACC_CSR_ADDR, 32'h38);
    cyc(2);
    chk("scan chan 0", 32'(conv_channel), 32'h0);
    cyc(ACC_FAST_STATES + 4);
    chk("scan chan 1", 32'(conv_channel), 32'h1);
    cyc(3 * ACC_FAST_STATES + 14);
    chk("scan runs", 32'(conv_active), 32'h1);
    rdr(ACC_CSR_ADDR);
    chk("scan flag", rd, 32'hB8);
    @(posedge aclk) standby_mode <= 1'h1;
    @(posedge aclk) standby_mode <= 1'h0;
    cyc(2);
    chk("standby stop", 32'(conv_active), 32'h0);
    wr(ACC_CSR_ADDR, 32'h38);
    @(posedge aclk) module_stop <= 1'h1;
    @(posedge aclk) module_stop <= 1'h0;
    cyc(2);
    chk("mstop stop", 32'(conv_active), 32'h0);
    wr(ACC_CSR_ADDR, 32'h38);
    @(posedge aclk) aresetn <= 1'h0;
    @(posedge aclk) aresetn <= 1'h1;
    rdr(ACC_CSR_ADDR);
    chk("reset stop", rd, 32'h0);
  endtask
  initial
  begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'h1;
    t_reset();
    t_slow();
    t_trig();
    t_scan();
    final_report();
  end
endmodule
bind acc_top acc_sva #(.NUM_CH(NUM_CH)) u_sva
(
  .aclk                    (aclk),
  .aresetn                 (aresetn),
  .s_axi_arvalid           (s_axi_arvalid),
  .s_axi_arready           (s_axi_arready),
  .s_axi_rvalid            (s_axi_rvalid),
  .s_axi_rready            (s_axi_rready),
  .s_axi_bvalid            (s_axi_bvalid),
  .s_axi_bready            (s_axi_bready),
  .timer_conv_trigger      (timer_conv_trigger),
  .external_conv_trigger_n (external_conv_trigger_n),
  .standby_mode            (standby_mode),
  .module_stop             (module_stop),
  .conv_active             (conv_active),
  .conv_end_irq            (conv_end_irq),
  .conv_channel            (conv_channel)
);
